// *** logic/fzio_pkg.sv ***
`default_nettype none
package fzio_pkg;
  // ==========================================================
  // Sizes
  localparam int NPIN_DEF = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_HOLD_EN = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PULL_EN = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PULL_UP = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_OUT_TYPE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_BIDIR_TYPE = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_HELD_IN = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PAD_IN = 5'h1C;

  // ==========================================================
  // Status fields and reset values
  localparam int STAT_FROZEN_BIT = 0;
  localparam int STAT_PIN_BIT = 1;
  localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;

  // ==========================================================
  // Freeze state
  typedef enum logic [1:0] {
    FZIO_ACTIVE = 2'b01,
    FZIO_FROZEN = 2'b10
  } fzio_state_t;
endpackage
`default_nettype wire

// *** logic/fzio_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module fzio_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // Two-stage synchroniser; first stage feeds only the second
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** logic/fzio_pad_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
module fzio_pad_cell (
  input wire logic frozen,
  input wire logic is_out,
  input wire logic is_bidir,
  input wire logic core_oe,
  input wire logic held_oe,
  input wire logic hold_en,
  input wire logic pull_en,
  input wire logic pull_up,
  input wire logic core_out,
  input wire logic held_out,
  input wire logic held_in,
  input wire logic pad_in,
  output logic pad_o,
  output logic pad_oe,
  output logic pad_pu,
  output logic pad_pd,
  output logic core_in
);
  // ==========================================================
  // Per-pad decision, one per pin so each pin decides alone
  logic drive_mode;
  logic frz_out_mode;

  always_comb begin
    drive_mode = is_out | (is_bidir & core_oe);
    // Bidir direction is the one latched at entry: core may be idle now
    frz_out_mode = is_out | (is_bidir & held_oe);
    pad_o = core_out;
    pad_oe = drive_mode;
    pad_pu = 1'b0;
    pad_pd = 1'b0;
    core_in = pad_in;
    if (frozen) begin
      pad_o = 1'b0;
      pad_oe = 1'b0;
      if (frz_out_mode && hold_en) begin
        pad_pu = held_out;
        pad_pd = ~held_out;
      end else if (pull_en) begin
        pad_pu = pull_up;
        pad_pd = ~pull_up;
      end
      // Neither hold nor pull leaves the pad floating
      core_in = hold_en ? (frz_out_mode ? held_out : held_in) : 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** logic/fzio_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module fzio_top
  import fzio_pkg::*;
#(
  parameter int NPIN = fzio_pkg::NPIN_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic freeze_request_pin,
  input wire logic [fzio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [fzio_pkg::DATA_W-1:0] avs_writedata,
  output logic [fzio_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  output logic [NPIN-1:0] core_in,
  input wire logic [NPIN-1:0] pad_i,
  output logic [NPIN-1:0] pad_o,
  output logic [NPIN-1:0] pad_oe,
  output logic [NPIN-1:0] pad_pu,
  output logic [NPIN-1:0] pad_pd,
  output logic frozen
);
  import fzio_pkg::*;

  // ==========================================================
  // Declarations
  logic pin_s;
  logic freeze_req;
  logic [NPIN-1:0] pad_in_s;
  fzio_state_t state_r;
  fzio_state_t state_nxt;
  logic [NPIN-1:0] hold_en_r;
  logic [NPIN-1:0] pull_en_r;
  logic [NPIN-1:0] pull_up_r;
  logic [NPIN-1:0] out_type_r;
  logic [NPIN-1:0] bidir_type_r;
  logic [NPIN-1:0] held_in_r;
  logic [NPIN-1:0] held_out_r;
  logic [NPIN-1:0] held_oe_r;
  logic [NPIN-1:0] c_pad_o;
  logic [NPIN-1:0] c_pad_oe;
  logic [NPIN-1:0] c_pad_pu;
  logic [NPIN-1:0] c_pad_pd;
  logic [NPIN-1:0] c_core_in;
  logic [DATA_W-1:0] rd_word;
  logic bus_req;
  logic wr_take;
  logic is_frozen;

  function automatic logic [DATA_W-1:0] to_word(input logic [NPIN-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[NPIN-1:0] = v;
    return w;
  endfunction

  function automatic logic [NPIN-1:0] from_word(input logic [DATA_W-1:0] w);
    return w[NPIN-1:0];
  endfunction

  // ==========================================================
  // Pin synchronisers
  // The freeze pin has no pull path at all in this block
  fzio_sync #(.W(1), .RST(1'b1)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(freeze_request_pin),
    .q(pin_s)
  );

  fzio_sync #(.W(NPIN), .RST('0)) u_pad_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pad_i),
    .q(pad_in_s)
  );

  assign freeze_req = ~pin_s;
  assign is_frozen = (state_r == FZIO_FROZEN);

  // ==========================================================
  // Freeze state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FZIO_ACTIVE: begin
        if (freeze_req) begin
          state_nxt = FZIO_FROZEN;
        end
      end
      FZIO_FROZEN: begin
        if (!freeze_req) begin
          state_nxt = FZIO_ACTIVE;
        end
      end
      default: begin
        state_nxt = FZIO_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= FZIO_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Entry capture: pad inputs, last driven outputs, direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_in_r <= '0;
      held_out_r <= '0;
      held_oe_r <= '0;
    end else if (state_r == FZIO_ACTIVE && freeze_req) begin
      held_in_r <= pad_in_s;
      held_out_r <= pad_o;
      held_oe_r <= core_oe;
    end
  end

  // ==========================================================
  // Pad cells
  for (genvar i = 0; i < NPIN; i++) begin : g_pad
    fzio_pad_cell u_cell (
      .frozen(is_frozen),
      .is_out(out_type_r[i]),
      .is_bidir(bidir_type_r[i]),
      .core_oe(core_oe[i]),
      .held_oe(held_oe_r[i]),
      .hold_en(hold_en_r[i]),
      .pull_en(pull_en_r[i]),
      .pull_up(pull_up_r[i]),
      .core_out(core_out[i]),
      .held_out(held_out_r[i]),
      .held_in(held_in_r[i]),
      .pad_in(pad_in_s[i]),
      .pad_o(c_pad_o[i]),
      .pad_oe(c_pad_oe[i]),
      .pad_pu(c_pad_pu[i]),
      .pad_pd(c_pad_pd[i]),
      .core_in(c_core_in[i])
    );
  end

  // Registered pad and core outputs: one cycle behind the cell
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_o <= '0;
      pad_oe <= '0;
      pad_pu <= '0;
      pad_pd <= '0;
      core_in <= '0;
      frozen <= 1'b0;
    end else begin
      pad_o <= c_pad_o;
      pad_oe <= c_pad_oe;
      pad_pu <= c_pad_pu;
      pad_pd <= c_pad_pd;
      core_in <= c_core_in;
      frozen <= is_frozen;
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then a single answer cycle
  assign bus_req = avs_read | avs_write;
  assign wr_take = avs_write & ~avs_waitrequest;

  always_comb begin
    unique case (avs_address)
      OFS_HOLD_EN: rd_word = to_word(hold_en_r);
      OFS_PULL_EN: rd_word = to_word(pull_en_r);
      OFS_PULL_UP: rd_word = to_word(pull_up_r);
      OFS_OUT_TYPE: rd_word = to_word(out_type_r);
      OFS_BIDIR_TYPE: rd_word = to_word(bidir_type_r);
      OFS_HELD_IN: rd_word = to_word(held_in_r);
      OFS_PAD_IN: rd_word = to_word(pad_in_s);
      OFS_STATUS: begin
        rd_word = RD_UNMAPPED;
        rd_word[STAT_FROZEN_BIT] = is_frozen;
        rd_word[STAT_PIN_BIT] = pin_s;
      end
      default: rd_word = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      // Low for exactly one cycle, so a held request is not taken twice
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // Configuration may change while frozen; it takes effect at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_en_r <= from_word(CFG_RST);
      pull_en_r <= from_word(CFG_RST);
      pull_up_r <= from_word(CFG_RST);
      out_type_r <= from_word(CFG_RST);
      bidir_type_r <= from_word(CFG_RST);
    end else if (wr_take) begin
      unique case (avs_address)
        OFS_HOLD_EN: hold_en_r <= from_word(avs_writedata);
        OFS_PULL_EN: pull_en_r <= from_word(avs_writedata);
        OFS_PULL_UP: pull_up_r <= from_word(avs_writedata);
        OFS_OUT_TYPE: out_type_r <= from_word(avs_writedata);
        OFS_BIDIR_TYPE: bidir_type_r <= from_word(avs_writedata);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions (every pin watched through per-pin masks)
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [NPIN-1:0] in_mode;
  logic [NPIN-1:0] hin_m;
  logic [NPIN-1:0] hout_m;
  logic [NPIN-1:0] pull_m;
  logic [NPIN-1:0] float_m;
  assign in_mode = ~out_type_r & ~(bidir_type_r & held_oe_r);
  assign hin_m = hold_en_r & in_mode;
  assign hout_m = hold_en_r & ~in_mode;
  assign pull_m = pull_en_r & ~hout_m;
  assign float_m = ~hout_m & ~pull_en_r;

  sequence s_exit;
    is_frozen && !freeze_req;
  endsequence

  sequence s_normal;
    !is_frozen ##1 (pad_pu == '0 && pad_pd == '0 && core_in == $past(pad_in_s));
  endsequence

  entry_capture_a: assert property (
    (state_r == FZIO_ACTIVE && freeze_req) |=> (is_frozen && held_in_r == $past(pad_in_s)))
    else $error("entry did not capture pad inputs");

  in_hold_keep_a: assert property (
    is_frozen |=> (((core_in ^ $past(held_in_r)) & $past(hin_m)) == '0))
    else $error("held input not kept");

  in_tie_high_a: assert property (
    is_frozen |=> ((core_in | $past(hold_en_r)) == '1))
    else $error("unheld input not high");

  tristate_pad_a: assert property (
    is_frozen |=> (pad_oe == '0 && ((pad_pu | pad_pd) & $past(float_m)) == '0))
    else $error("unconfigured pad not tristated");

  weak_pull_a: assert property (
    is_frozen
      |=> (((pad_pu ^ $past(pull_up_r)) & $past(pull_m)) == '0
        && ((pad_pd ^ ~$past(pull_up_r)) & $past(pull_m)) == '0))
    else $error("weak pull not applied");

  out_hold_pull_a: assert property (
    is_frozen
      |=> (((pad_pu ^ $past(held_out_r)) & $past(hout_m)) == '0
        && ((pad_pd ^ ~$past(held_out_r)) & $past(hout_m)) == '0))
    else $error("output not pulled to held value");

  bidir_out_hold_a: assert property (
    is_frozen |=> (((core_in ^ $past(held_out_r)) & $past(hout_m)) == '0))
    else $error("bidir output mode hold wrong");

  exit_restore_a: assert property (
    s_exit |=> s_normal)
    else $error("pad overrides not released on exit");

  bus_answer_a: assert property (
    (bus_req && avs_waitrequest) |=> (!avs_waitrequest ##1 avs_waitrequest))
    else $error("waitrequest answer not one cycle");
endmodule
`default_nettype wire

// *** tb/fzio_board.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Board circuitry on the pads
module fzio_board #(
  parameter int NPIN = 8
) (
  input wire logic clk,
  input wire logic [NPIN-1:0] pad_o,
  input wire logic [NPIN-1:0] pad_oe,
  input wire logic [NPIN-1:0] pad_pu,
  input wire logic [NPIN-1:0] pad_pd,
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pad_i
);
  logic [NPIN-1:0] wander_r = '0;
  // A floating pad wanders, so no one may rely on its last level
  always @(posedge clk) begin
    wander_r <= ~wander_r;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) begin
        pad_i[i] = pad_o[i];
      end else if (ext_en[i]) begin
        pad_i[i] = ext_val[i];
      end else if (pad_pu[i]) begin
        pad_i[i] = 1'b1;
      end else if (pad_pd[i]) begin
        pad_i[i] = 1'b0;
      end else begin
        pad_i[i] = wander_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/test_fzio_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_fzio_top;
  import fzio_pkg::*;
  logic clk = 0, rst_n = 0, frz_n = 1, rd = 0, wr = 0, wreq, frozen;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0, rdat, v;
  logic [7:0] c_out = 8'h10, c_oe = 8'h80, c_in, p_i, p_o, p_oe, pu, pd;
  logic [7:0] x_en = 8'h0F, x_val = 8'h01;
  int mismatches = 0, n_tests = 0;
  // ==========================================
  // Clock, design and board
  always #4 clk = ~clk;
  fzio_top #(.NPIN(8)) DUT (.clk(clk), .rst_n(rst_n), .freeze_request_pin(frz_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .core_out(c_out), .core_oe(c_oe),
    .core_in(c_in), .pad_i(p_i), .pad_o(p_o), .pad_oe(p_oe), .pad_pu(pu), .pad_pd(pd),
    .frozen(frozen));
  fzio_board #(.NPIN(8)) board (.clk(clk), .pad_o(p_o), .pad_oe(p_oe), .pad_pu(pu),
    .pad_pd(pd), .ext_en(x_en), .ext_val(x_val), .pad_i(p_i));
  // ==========================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    // Request held until the edge that sees waitrequest low
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fz(input logic lvl);
    frz_n <= lvl;
    for (int i = 0; i < 20 && frozen !== ~lvl; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("frozen", {31'h0, frozen}, {31'h0, ~lvl});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, OFS_HOLD_EN, '0);
    chk("hold_rst", v, CFG_RST);
    bus(0, 5'h01, '0);
    chk("unmapped", v, RD_UNMAPPED);
    // Pins 0-3 inputs, 4-6 outputs, 7 bidir; each with its own mix
    bus(1, OFS_HOLD_EN, 32'h95);
    bus(1, OFS_PULL_EN, 32'h33);
    bus(1, OFS_PULL_UP, 32'h21);
    bus(1, OFS_OUT_TYPE, 32'h70);
    bus(1, OFS_BIDIR_TYPE, 32'h80);
    bus(0, OFS_HOLD_EN, '0);
    chk("hold_rd", v, 32'h95);
    repeat (4) @(posedge clk);
    fz(1'b0);
    chk("pu", pu, 8'h31);
    chk("pd", pd, 8'h82);
    chk("oe", p_oe, 8'h00);
    chk("po", p_o, 8'h00);
    chk("cin", c_in & 8'h8F, 8'h0B);
    // Pad moves and floats while input hold is in force
    x_val <= 8'h04;
    x_en <= 8'h07;
    repeat (6) @(posedge clk);
    chk("cin_keep", c_in & 8'h8F, 8'h0B);
    bus(0, OFS_STATUS, '0);
    chk("status", v, 32'h1);
    bus(0, OFS_HELD_IN, '0);
    chk("held_in", v, 32'h11);
    fz(1'b1);
    chk("oe_x", p_oe, 8'hF0);
    chk("pupd_x", {pu, pd}, 16'h0);
    chk("po_x", p_o & 8'hF0, 8'h10);
    chk("cin_x", c_in & 8'h07, 8'h04);
    bus(0, OFS_PAD_IN, '0);
    chk("pad_in", v & 32'hF7, 32'h14);
    // Bidir in input mode follows the input rules
    c_oe <= 8'h00;
    x_en <= 8'h87;
    x_val <= 8'h04;
    repeat (6) @(posedge clk);
    fz(1'b0);
    chk("bi_pull", {pu[7], pd[7], p_oe[7]}, 3'b000);
    chk("bi_cin", c_in[7], 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
